/* hw/wrs_pkg.sv */
// wake-up / reset state logic: constants and types
package wrs_pkg;
	localparam int          PC_W          = 21;
	localparam int          SP_W          = 5;
	localparam int          OSC_W         = 4;
	localparam logic [20:0] PC_RESET      = 21'h000000;
	localparam logic [20:0] VEC_HIGH      = 21'h000008;
	localparam logic [20:0] VEC_LOW       = 21'h000018;
	localparam logic [4:0]  SP_RESET      = 5'h00;
	localparam int          PA_BIT6       = 6;
	localparam logic [7:0]  PA_MASK_OFF   = 8'hbf;
	localparam logic [7:0]  PA_LAT_RESET  = 8'h00;
	localparam logic [7:0]  PA_DIR_RESET  = 8'h7f;
	localparam logic [3:0]  OSC_EXT_CLOCK_IO_OSC_MODE      = 4'h5;
	localparam logic [3:0]  OSC_RC_IO_OSC_MODE      = 4'h7;

	typedef enum logic [1:0] {
		WRS_EV_NONE,
		WRS_EV_POR,
		WRS_EV_RST,
		WRS_EV_WAKE
	} wrs_event_e;
endpackage

/* hw/wrs_port_if.sv */
// carrier between the sequencer and the port a bit-6 gate
`timescale 1ns/100ps
interface wrs_port_if;
	logic [3:0] osc_mode;
	logic       bit6_present;
	logic [7:0] pins_raw;
	logic [7:0] latch_raw;
	logic [7:0] dir_raw;
	logic [7:0] pins_rd;
	logic [7:0] latch_rd;
	logic [7:0] dir_rd;
	modport core (output osc_mode, bit6_present, pins_raw, latch_raw, dir_raw,
		input pins_rd, latch_rd, dir_rd);
	modport gate (input osc_mode, bit6_present, pins_raw, latch_raw, dir_raw,
		output pins_rd, latch_rd, dir_rd);
endinterface

/* hw/wrs_port_gate.sv */
// port a read gating for bit 6
`timescale 1ns/100ps
module wrs_port_gate (
	wrs_port_if.gate p
);
	logic       bit6_on;
	logic [7:0] mask;

	// ----------------------------------------
	// bit-6 enable
	// ----------------------------------------
	always_comb begin
		bit6_on = p.bit6_present && ((p.osc_mode == wrs_pkg::OSC_EXT_CLOCK_IO_OSC_MODE) ||
			(p.osc_mode == wrs_pkg::OSC_RC_IO_OSC_MODE));
		mask = bit6_on ? 8'hff : wrs_pkg::PA_MASK_OFF;
		p.pins_rd  = p.pins_raw & mask;
		p.latch_rd = p.latch_raw & mask;
		p.dir_rd   = p.dir_raw & mask;
	end
endmodule

/* hw/wrs_top.sv */
// wake-up and reset state sequencer of the core
`timescale 1ns/100ps
module wrs_top #(
	parameter logic BIT6_PRESENT = 1'b1
) (
	// clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// reset and wake sources, one-cycle pulses, plus the irq_wake_high vector select level
	input  wire logic        por_bor_evt,
	input  wire logic        ext_reset_evt,
	input  wire logic        wdt_reset_evt,
	input  wire logic        reset_instr_evt,
	input  wire logic        stack_reset_evt,
	input  wire logic        wdt_wake_evt,
	input  wire logic        irq_wake_evt,
	input  wire logic        irq_wake_high,
	// core state
	input  wire logic        sleeping,
	input  wire logic [20:0] current_pc,
	input  wire logic        low_prio_global_irq_enable,
	input  wire logic        high_prio_global_irq_enable,
	// port a
	input  wire logic [3:0]  osc_mode,
	input  wire logic [7:0]  port_a_pins,
	input  wire logic        port_a_latch_we,
	input  wire logic [7:0]  port_a_latch_wdata,
	input  wire logic        port_a_direction_we,
	input  wire logic [7:0]  port_a_direction_wdata,
	// results
	output logic      [20:0] pc_out,
	output logic             pc_load,
	output logic      [7:0]  stack_top_upper,
	output logic      [7:0]  stack_top_high,
	output logic      [7:0]  stack_top_low,
	output logic      [4:0]  stack_pointer_reg,
	output logic             wake_cause_set,
	output logic             wake_by_wdt,
	output logic      [1:0]  last_event,
	output logic      [7:0]  port_a_pins_rd,
	output logic      [7:0]  port_a_latch_rd,
	output logic      [7:0]  port_a_direction_rd
);
	typedef struct packed {
		logic [20:0] pc;
		logic        pc_load;
		logic [7:0]  tos_u;
		logic [7:0]  tos_h;
		logic [7:0]  tos_l;
		logic [4:0]  sp;
		logic        cause;
		logic        by_wdt;
		wrs_pkg::wrs_event_e ev;
		logic [7:0]  latch;
		logic [7:0]  dir;
		logic [7:0]  pins_rd;
		logic [7:0]  latch_rd;
		logic [7:0]  dir_rd;
	} wrs_state_s;

	logic [1:0] rst_sync_ff;
	logic       rst_q_n;
	wrs_state_s st_ff;
	wrs_state_s nxt_st;
	logic       other_rst;
	logic       wake_any;
	logic       vector_go;
	logic [20:0] vec;

	wrs_port_if pif ();

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	// release is synchronised so every st_ff flop leaves reset on the same edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_q_n = rst_sync_ff[1];

	// ----------------------------------------
	// port gate
	// ----------------------------------------
	assign pif.osc_mode     = osc_mode;
	assign pif.bit6_present = BIT6_PRESENT;
	assign pif.pins_raw     = port_a_pins;
	assign pif.latch_raw    = st_ff.latch;
	assign pif.dir_raw      = st_ff.dir;

	wrs_port_gate u_gate (
		.p (pif.gate)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_st    = st_ff;
		other_rst = ext_reset_evt | wdt_reset_evt | reset_instr_evt | stack_reset_evt;
		wake_any  = sleeping & (wdt_wake_evt | irq_wake_evt);
		vector_go = sleeping & irq_wake_evt &
			(low_prio_global_irq_enable | high_prio_global_irq_enable);
		vec = irq_wake_high ? wrs_pkg::VEC_HIGH : wrs_pkg::VEC_LOW;
		nxt_st.pc_load  = 1'b0;
		nxt_st.pins_rd  = pif.pins_rd;
		nxt_st.latch_rd = pif.latch_rd;
		nxt_st.dir_rd   = pif.dir_rd;
		if (port_a_latch_we) begin
			nxt_st.latch = port_a_latch_wdata;
		end
		if (port_a_direction_we) begin
			nxt_st.dir = port_a_direction_wdata;
		end
		// priority: power-on beats other resets beats wake-up
		if (por_bor_evt) begin
			nxt_st.ev      = wrs_pkg::WRS_EV_POR;
			nxt_st.pc      = wrs_pkg::PC_RESET;
			nxt_st.pc_load = 1'b1;
			nxt_st.sp      = wrs_pkg::SP_RESET;
			nxt_st.cause   = 1'b0;
			nxt_st.by_wdt  = 1'b0;
			nxt_st.latch   = wrs_pkg::PA_LAT_RESET;
			nxt_st.dir     = wrs_pkg::PA_DIR_RESET;
		end else if (other_rst) begin
			nxt_st.ev      = wrs_pkg::WRS_EV_RST;
			nxt_st.pc      = wrs_pkg::PC_RESET;
			nxt_st.pc_load = 1'b1;
			nxt_st.dir     = wrs_pkg::PA_DIR_RESET;
			// stack pointer, latch and tos bytes are left unchanged here
		end else if (wake_any) begin
			nxt_st.ev     = wrs_pkg::WRS_EV_WAKE;
			nxt_st.cause  = 1'b1;
			nxt_st.by_wdt = wdt_wake_evt & ~irq_wake_evt;
			if (vector_go) begin
				nxt_st.pc      = vec;
				nxt_st.pc_load = 1'b1;
				nxt_st.tos_u   = {3'h0, current_pc[20:16]};
				nxt_st.tos_h   = current_pc[15:8];
				nxt_st.tos_l   = current_pc[7:0];
				nxt_st.sp      = st_ff.sp + 5'h01;
			end
			// other fields keep their value across the wake-up
		end
	end

	always_ff @(posedge clock or negedge rst_q_n) begin
		if (!rst_q_n) begin
			st_ff <= '0;
			st_ff.dir <= wrs_pkg::PA_DIR_RESET;
			st_ff.dir_rd <= wrs_pkg::PA_DIR_RESET & wrs_pkg::PA_MASK_OFF;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign pc_out              = st_ff.pc;
	assign pc_load             = st_ff.pc_load;
	assign stack_top_upper     = st_ff.tos_u;
	assign stack_top_high      = st_ff.tos_h;
	assign stack_top_low       = st_ff.tos_l;
	assign stack_pointer_reg   = st_ff.sp;
	assign wake_cause_set      = st_ff.cause;
	assign wake_by_wdt         = st_ff.by_wdt;
	assign last_event          = st_ff.ev;
	assign port_a_pins_rd      = st_ff.pins_rd;
	assign port_a_latch_rd     = st_ff.latch_rd;
	assign port_a_direction_rd = st_ff.dir_rd;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_vec_wake;
		clk_en && !por_bor_evt && !other_rst && vector_go;
	endsequence

	chk_wake_cause_flag: assert property (@(posedge clock) disable iff (!rst_q_n)
		(clk_en && !por_bor_evt && !other_rst && wake_any) |=> wake_cause_set)
		else $error("wake-up did not set cause flag");

	chk_vector_load: assert property (@(posedge clock) disable iff (!rst_q_n)
		s_vec_wake |=> pc_load &&
		(pc_out == ($past(irq_wake_high) ? wrs_pkg::VEC_HIGH : wrs_pkg::VEC_LOW)))
		else $error("interrupt wake did not load vector");

	chk_tos_capture: assert property (@(posedge clock) disable iff (!rst_q_n)
		s_vec_wake |=> {stack_top_upper[4:0], stack_top_high, stack_top_low} == $past(current_pc))
		else $error("top of stack not loaded with pc");

	chk_sp_advance: assert property (@(posedge clock) disable iff (!rst_q_n)
		s_vec_wake |=> stack_pointer_reg == $past(stack_pointer_reg) + 5'h01)
		else $error("stack pointer did not advance");

	chk_bit6_mode: assert property (@(posedge clock) disable iff (!rst_q_n)
		(clk_en && osc_mode != wrs_pkg::OSC_EXT_CLOCK_IO_OSC_MODE && osc_mode != wrs_pkg::OSC_RC_IO_OSC_MODE)
		|=> !port_a_latch_rd[wrs_pkg::PA_BIT6] && !port_a_direction_rd[wrs_pkg::PA_BIT6])
		else $error("port a bit 6 visible in wrong mode");

	chk_bit6_absent: assert property (@(posedge clock) disable iff (!rst_q_n)
		!BIT6_PRESENT |-> !port_a_pins_rd[wrs_pkg::PA_BIT6] &&
		!port_a_latch_rd[wrs_pkg::PA_BIT6] && !port_a_direction_rd[wrs_pkg::PA_BIT6])
		else $error("absent bit 6 reads one");

	chk_unused_tos: assert property (@(posedge clock) disable iff (!rst_q_n)
		stack_top_upper[7:5] == 3'h0)
		else $error("unimplemented tos bits nonzero");

	chk_event_class: assert property (@(posedge clock) disable iff (!rst_q_n)
		(clk_en && por_bor_evt) |=> last_event == wrs_pkg::WRS_EV_POR && stack_pointer_reg == 5'h00)
		else $error("power-on class not recorded");

	chk_sp_kept_rst: assert property (@(posedge clock) disable iff (!rst_q_n)
		(clk_en && !por_bor_evt && other_rst) |=> $stable(stack_pointer_reg))
		else $error("stack pointer changed on other reset");

	chk_tos_kept_rst: assert property (@(posedge clock) disable iff (!rst_q_n)
		(clk_en && !por_bor_evt && other_rst)
		|=> $stable({stack_top_upper, stack_top_high, stack_top_low}))
		else $error("top of stack changed on other reset");

	// wake pulses while awake must leave no trace at all
	chk_wake_needs_sleep: assert property (@(posedge clock) disable iff (!rst_q_n)
		(clk_en && !sleeping && !por_bor_evt && !other_rst) |=> !pc_load && $stable(last_event))
		else $error("wake event acted while awake");
endmodule

/* bench/wrs_src_model.sv */
// partner model: interrupt and reset event sources
`timescale 1ns/100ps
module wrs_src_model (
	// request from the bench
	input  wire logic       go,
	input  wire logic [2:0] sel,
	// pulses toward the core
	output logic      [6:0] evt
);
	// one source per cycle; coincident sources are left to a later bench
	always_comb begin
		evt = 7'h00;
		if (go) begin
			evt[sel] = 1'b1;
		end
	end
endmodule

/* bench/tb.sv */
// self-checking bench for the wake-up and reset state sequencer
`timescale 1ns/100ps
module tb;
	logic        clock = 0, rst_n = 0, clk_en = 1, go = 0, sleeping = 0;
	logic        irq_wake_high = 0, port_a_latch_we = 0, port_a_direction_we = 0;
	logic        low_prio_global_irq_enable = 0, high_prio_global_irq_enable = 0;
	logic [2:0]  sel = 0;
	logic [6:0]  evt;
	logic [20:0] current_pc = 0, pc_out, tos = 0;
	logic [3:0]  osc_mode = 0;
	logic [7:0]  port_a_pins = 0, port_a_latch_wdata = 0, port_a_direction_wdata = 0;
	logic [7:0]  stack_top_upper, stack_top_high, stack_top_low, lat, msk;
	logic [7:0]  port_a_pins_rd, port_a_latch_rd, port_a_direction_rd;
	logic [7:0]  nb_pins_rd, nb_latch_rd, nb_dir_rd;
	logic [4:0]  stack_pointer_reg, sp;
	logic [1:0]  last_event;
	logic        pc_load, wake_cause_set, wake_by_wdt;
	logic [63:0] q[$];
	int          miscompares = 0, samples_checked = 0, seed, i;

	always #2 clock = ~clock;

	wrs_src_model SRC (.go, .sel, .evt);
	wrs_top DUT (.clock, .rst_n, .clk_en, .por_bor_evt(evt[0]), .ext_reset_evt(evt[1]),
		.wdt_reset_evt(evt[2]), .reset_instr_evt(evt[3]), .stack_reset_evt(evt[4]),
		.wdt_wake_evt(evt[5]), .irq_wake_evt(evt[6]), .irq_wake_high, .sleeping,
		.current_pc, .low_prio_global_irq_enable, .high_prio_global_irq_enable, .osc_mode,
		.port_a_pins, .port_a_latch_we, .port_a_latch_wdata, .port_a_direction_we,
		.port_a_direction_wdata, .pc_out, .pc_load, .stack_top_upper, .stack_top_high,
		.stack_top_low, .stack_pointer_reg, .wake_cause_set, .wake_by_wdt, .last_event,
		.port_a_pins_rd, .port_a_latch_rd, .port_a_direction_rd);
	// variant without port a bit 6, same stimulus
	wrs_top #(.BIT6_PRESENT(1'b0)) DUT_NB (.clock, .rst_n, .clk_en, .por_bor_evt(evt[0]),
		.ext_reset_evt(evt[1]), .wdt_reset_evt(evt[2]), .reset_instr_evt(evt[3]),
		.stack_reset_evt(evt[4]), .wdt_wake_evt(evt[5]), .irq_wake_evt(evt[6]), .irq_wake_high,
		.sleeping, .current_pc, .low_prio_global_irq_enable, .high_prio_global_irq_enable,
		.osc_mode, .port_a_pins, .port_a_latch_we, .port_a_latch_wdata, .port_a_direction_we,
		.port_a_direction_wdata, .pc_out(), .pc_load(), .stack_top_upper(), .stack_top_high(),
		.stack_top_low(), .stack_pointer_reg(), .wake_cause_set(), .wake_by_wdt(),
		.last_event(), .port_a_pins_rd(nb_pins_rd), .port_a_latch_rd(nb_latch_rd),
		.port_a_direction_rd(nb_dir_rd));

	task cmp(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task stop_test;
		$display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// -----------------------------
	// result watcher
	// -----------------------------
	always @(negedge clock) begin
		if (pc_load === 1'b1) begin
			if (q.size() == 0) cmp(64'h1, 64'h0);
			else cmp({pc_out, stack_pointer_reg, stack_top_upper, stack_top_high,
				stack_top_low}, q.pop_front());
		end
	end

	// hold fire on the event line so back-to-back pulses stay one driver step each
	// every reset also pulses the pc load; a frozen core takes nothing
	task fire(input logic [2:0] s);
		sel = s;
		go = 1'b1;
		current_pc = 21'($random(seed));
		if (clk_en && s <= 3'h4) begin
			if (s == 3'h0) sp = wrs_pkg::SP_RESET;
			q.push_back({wrs_pkg::PC_RESET, sp, 3'h0, tos});
		end else if (clk_en && s == 3'h6 && sleeping &&
				(low_prio_global_irq_enable | high_prio_global_irq_enable)) begin
			sp = sp + 5'h01;
			tos = current_pc;
			q.push_back({irq_wake_high ? wrs_pkg::VEC_HIGH : wrs_pkg::VEC_LOW, sp, 3'h0, tos});
		end
		@(negedge clock);
	endtask

	initial begin
		seed = 47127;
		sp = 5'h00;
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		cmp(port_a_direction_rd, 8'h3f);
		cmp(wake_cause_set, 0);
		// port a bit 6 across every oscillator code
		for (i = 0; i < 16; i++) begin
			osc_mode = 4'(i);
			msk = (osc_mode == wrs_pkg::OSC_EXT_CLOCK_IO_OSC_MODE || osc_mode == wrs_pkg::OSC_RC_IO_OSC_MODE) ? 8'hff :
				wrs_pkg::PA_MASK_OFF;
			port_a_pins = 8'($random(seed));
			lat = 8'($random(seed));
			port_a_latch_wdata = lat;
			port_a_direction_wdata = ~lat;
			port_a_latch_we = 1'b1;
			port_a_direction_we = 1'b1;
			repeat (2) @(negedge clock);
			cmp(port_a_pins_rd, port_a_pins & msk);
			cmp(port_a_latch_rd, lat & msk);
			cmp(port_a_direction_rd, ~lat & msk);
			cmp({nb_pins_rd, nb_latch_rd, nb_dir_rd}, {port_a_pins, lat, ~lat} & {3{8'hbf}});
		end
		port_a_latch_we = 1'b0;
		port_a_direction_we = 1'b0;
		// wake paths, interrupts back to back
		sleeping = 1'b1;
		fire(3'h5);
		for (i = 0; i < 4; i++) begin
			{high_prio_global_irq_enable, low_prio_global_irq_enable} = 2'(i);
			irq_wake_high = i[0];
			fire(3'h6);
		end
		go = 1'b0;
		repeat (2) @(negedge clock);
		cmp({wake_cause_set, wake_by_wdt, last_event}, {2'b10, wrs_pkg::WRS_EV_WAKE});
		// other resets keep stack and latch, then a wake while awake is ignored
		sleeping = 1'b0;
		for (i = 1; i < 5; i++) fire(3'(i));
		fire(3'h6);
		// clock enable low: this power-on pulse must be lost
		clk_en = 1'b0;
		fire(3'h0);
		clk_en = 1'b1;
		go = 1'b0;
		repeat (2) @(negedge clock);
		cmp({last_event, stack_pointer_reg, port_a_latch_rd}, {wrs_pkg::WRS_EV_RST, sp, lat & msk});
		cmp(port_a_direction_rd, 8'h7f & msk);
		fire(3'h0);
		go = 1'b0;
		repeat (2) @(negedge clock);
		cmp({last_event, stack_pointer_reg, port_a_latch_rd},
			{wrs_pkg::WRS_EV_POR, wrs_pkg::SP_RESET, wrs_pkg::PA_LAT_RESET});
		cmp(wake_cause_set, 0);
		cmp(q.size(), 0);
		stop_test;
	end

	initial begin
		repeat (5000) @(posedge clock);
		miscompares++;
		stop_test;
	end
endmodule
